// >>> uhprs_pkg.sv
// Contract
// [R1] Software sets the configure flag only as its final configuration step.
// [R2] Configure flag 0 routes every port to a companion classic controller.
// [R3] Configure flag 1 routes all ports to the enhanced controller.
// [R4] Port registers reset only on auxiliary power-up or controller reset.
// [R5] After reset each port shows no device connected and disabled.
// [R6] Port state changes are ignored until port power is on.
// [R7] Software waits up to 20 ms for port power to settle.
// [R8] Port n register sits at offset 64h plus 4 times (n minus 1).
// [R9] Wake-on-overcurrent enable in bit 22 makes overcurrent a wake event.
// [R10] Wake-on-disconnect enable in bit 21 makes disconnect a wake event.
// [R11] Wake-on-connect enable in bit 20 makes connect a wake event.
// [R12] Software writes reserved bits with their reset value.
// [R13] Ownership clears when configure flag rises, forced to 1 while flag is 0.
// [R14] Ownership 1 means a companion classic controller controls the port.
// [R15] Software writes to read-only port status fields are ignored.
package uhprs_pkg;

	localparam int          NPORT           = 2;
	localparam int          AW              = 8;
	localparam logic [7:0]  ADDR_CONFIGURE  = 8'h60;
	localparam logic [7:0]  ADDR_PORT_BASE  = 8'h64;
	localparam logic [7:0]  ADDR_PORT_STEP  = 8'h04;
	localparam logic [31:0] CONFIGURE_RESET = 32'h0000_0000;
	localparam int          CF_BIT          = 0;
	localparam int          WAKE_OC_BIT     = 22;
	localparam int          WAKE_DETACH_BIT = 21;
	localparam int          WAKE_ATTACH_BIT = 20;
	localparam int          OWNER_BIT       = 13;
	localparam logic [31:0] PORT_RESET      = 32'h0000_2000;

	// Field layout of one downstream status and control word, bit 31 first.
	typedef struct packed {
		logic [8:0] rsvd_hi;
		logic       wake_on_overcurrent_en;
		logic       wake_on_detach_en;
		logic       wake_on_attach_en;
		logic [3:0] test_select;
		logic [1:0] rsvd_mid;
		logic       companion_owner;
		logic       power_switch_on;
		logic [1:0] line_state;
		logic       rsvd_lo;
		logic       reset_active;
		logic       sleep_state;
		logic       forced_resume;
		logic       overcurrent_change;
		logic       overcurrent_active;
		logic       link_enable_change;
		logic       link_enabled;
		logic       connect_change;
		logic       connect_status;
	} uhprs_downstream_status_control_t;

	// Pins of one port facing the transceiver and power switch.
	typedef struct packed {
		logic       attach;
		logic       overcurrent;
		logic [1:0] line_state;
	} uhprs_pin_t;

endpackage : uhprs_pkg

// >>> uhprs_port.sv
`timescale 1ns/1ps
module uhprs_port
	import uhprs_pkg::*;
(
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          aux_por,
	input  wire logic          cf_q,
	input  wire logic          cf_rise,
	input  wire logic          wr_en,
	input  wire uhprs_downstream_status_control_t wdata,
	input  wire uhprs_pin_t    pin,
	output uhprs_downstream_status_control_t      downstream_status_control_q,
	output logic               wake_q
);

	uhprs_downstream_status_control_t downstream_status_control_d;
	logic          wake_d;
	wire           port_rst    = rst | aux_por;
	wire           attach_rise = pin.attach & ~downstream_status_control_q.connect_status;
	wire           attach_fall = ~pin.attach & downstream_status_control_q.connect_status;
	wire           oc_rise     = pin.overcurrent & ~downstream_status_control_q.overcurrent_active;
	wire           powered     = downstream_status_control_q.power_switch_on;
	wire           state_wr    = wr_en & powered;
	wire           drop_enable = downstream_status_control_q.link_enabled & (attach_fall | pin.overcurrent | ~powered);

	// ==========================================================
	// Next state
	always_comb begin
		downstream_status_control_d = downstream_status_control_q;
		downstream_status_control_d.rsvd_hi  = '0;
		downstream_status_control_d.rsvd_mid = '0;
		downstream_status_control_d.rsvd_lo  = 1'b0;
		// [R15] status follows pins
		downstream_status_control_d.connect_status     = pin.attach;
		downstream_status_control_d.overcurrent_active = pin.overcurrent;
		downstream_status_control_d.line_state         = pin.line_state;
		downstream_status_control_d.reset_active       = 1'b0;
		downstream_status_control_d.overcurrent_change = downstream_status_control_q.overcurrent_change | (pin.overcurrent ^ downstream_status_control_q.overcurrent_active);
		if (wr_en) begin
			downstream_status_control_d.wake_on_overcurrent_en = wdata.wake_on_overcurrent_en;
			downstream_status_control_d.wake_on_detach_en      = wdata.wake_on_detach_en;
			downstream_status_control_d.wake_on_attach_en      = wdata.wake_on_attach_en;
			downstream_status_control_d.power_switch_on        = wdata.power_switch_on;
		end
		// [R6] power gates state
		if (state_wr) begin
			downstream_status_control_d.test_select   = wdata.test_select;
			downstream_status_control_d.sleep_state   = wdata.sleep_state;
			downstream_status_control_d.forced_resume = wdata.forced_resume;
			downstream_status_control_d.link_enabled  = wdata.link_enabled & pin.attach & ~downstream_status_control_q.companion_owner;
		end
		// Connect and enable change flags clear by writing one; a new event in the same cycle wins.
		if (wr_en && wdata.connect_change)
			downstream_status_control_d.connect_change = 1'b0;
		if (wr_en && wdata.link_enable_change)
			downstream_status_control_d.link_enable_change = 1'b0;
		if (attach_rise || attach_fall)
			downstream_status_control_d.connect_change = 1'b1;
		if (drop_enable) begin
			downstream_status_control_d.link_enabled       = 1'b0;
			downstream_status_control_d.link_enable_change = 1'b1;
		end
		// [R13] ownership follows flag
		if (!cf_q)
			downstream_status_control_d.companion_owner = 1'b1;
		else if (cf_rise)
			downstream_status_control_d.companion_owner = 1'b0;
		else if (wr_en)
			downstream_status_control_d.companion_owner = wdata.companion_owner;
	end

	// [R9] [R10] [R11] wake events
	assign wake_d = (downstream_status_control_q.wake_on_attach_en & attach_rise)
		| (downstream_status_control_q.wake_on_detach_en & attach_fall)
		| (downstream_status_control_q.wake_on_overcurrent_en & oc_rise);

	// ==========================================================
	// Registers
	// [R4] [R5] aux or controller reset
	always_ff @(posedge clk_sys) begin
		if (port_rst) begin
			downstream_status_control_q <= PORT_RESET;
			wake_q   <= 1'b0;
		end else begin
			downstream_status_control_q <= downstream_status_control_d;
			wake_q   <= wake_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (port_rst);

	owner_forced_a: assert property (!cf_q |=> downstream_status_control_q.companion_owner) // [R13]
		else $error("owner not forced while configure flag low");
	owner_clear_a: assert property (cf_rise |=> !downstream_status_control_q.companion_owner) // [R13]
		else $error("owner not cleared on configure flag rise");
	wake_attach_a: assert property (downstream_status_control_q.wake_on_attach_en && attach_rise |=> wake_q) // [R11]
		else $error("connect wake missed");
	wake_detach_a: assert property (downstream_status_control_q.wake_on_detach_en && attach_fall |=> wake_q) // [R10]
		else $error("disconnect wake missed");
	wake_oc_a: assert property (downstream_status_control_q.wake_on_overcurrent_en && oc_rise |=> wake_q) // [R9]
		else $error("overcurrent wake missed");
	wake_quiet_a: assert property (wake_q |-> $past(downstream_status_control_q.wake_on_attach_en | downstream_status_control_q.wake_on_detach_en
		| downstream_status_control_q.wake_on_overcurrent_en)) // [R11]
		else $error("wake without enable");
	power_gate_a: assert property (wr_en && !powered |=> $stable(downstream_status_control_q.sleep_state)
		&& $stable(downstream_status_control_q.test_select) && $stable(downstream_status_control_q.forced_resume)) // [R6]
		else $error("state changed without port power");
	ro_field_a: assert property (wr_en |=> downstream_status_control_q.connect_status == $past(pin.attach)
		&& downstream_status_control_q.overcurrent_active == $past(pin.overcurrent) && !downstream_status_control_q.reset_active) // [R15]
		else $error("read-only field took write data");
	enable_drop_a: assert property (downstream_status_control_q.link_enabled && !pin.attach |=> !downstream_status_control_q.link_enabled
		##0 downstream_status_control_q.link_enable_change) // [R6]
		else $error("enable kept after disconnect");
	cover_wake_c: cover property (attach_rise ##1 wake_q);
	cover_ready_c: cover property (powered && cf_q ##1 downstream_status_control_q.link_enabled);

endmodule : uhprs_port

// >>> uhprs_top.sv
`timescale 1ns/1ps
module uhprs_top
	import uhprs_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire logic                   aux_por,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic [AW-1:0]          reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire uhprs_pin_t [NPORT-1:0] port_pin,
	output logic [31:0]                 reg_rdata_q,
	output logic                        configure_done_flag_q,
	output logic [NPORT-1:0]            route_companion_q,
	output logic [NPORT-1:0]            wake_q
);

	// ==========================================================
	// Configure flag
	logic          cf_prev_q;
	wire           cf_rise  = configure_done_flag_q & ~cf_prev_q;
	wire           cfg_hit  = (reg_addr == ADDR_CONFIGURE);
	wire           cfg_wr   = reg_wr & cfg_hit;
	wire           cf_d     = cfg_wr ? reg_wdata[CF_BIT] : configure_done_flag_q;

	// Only the flag itself is stored; reserved bits read back as zero.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			configure_done_flag_q <= CONFIGURE_RESET[CF_BIT];
			cf_prev_q             <= CONFIGURE_RESET[CF_BIT];
		end else begin
			configure_done_flag_q <= cf_d;
			cf_prev_q             <= configure_done_flag_q;
		end
	end

	// ==========================================================
	// Ports
	uhprs_downstream_status_control_t [NPORT-1:0] downstream_status_control;
	logic [NPORT-1:0]          port_hit;
	logic [NPORT-1:0]          owner_d;

	for (genvar n = 0; n < NPORT; n++) begin : g_port
		// [R8] port offset decode
		assign port_hit[n] = (reg_addr == ADDR_PORT_BASE + 8'(n) * ADDR_PORT_STEP);
		// [R14] owner picks controller
		assign owner_d[n]  = downstream_status_control[n].companion_owner;

		uhprs_port u_port (
			.clk_sys  (clk_sys),
			.rst      (rst),
			.aux_por  (aux_por),
			.cf_q     (configure_done_flag_q),
			.cf_rise  (cf_rise),
			.wr_en    (reg_wr & port_hit[n]),
			.wdata    (uhprs_downstream_status_control_t'(reg_wdata)),
			.pin      (port_pin[n]),
			.downstream_status_control_q (downstream_status_control[n]),
			.wake_q   (wake_q[n])
		);
	end

	// ==========================================================
	// Read path
	wire [31:0] rdata_d = !reg_rd    ? reg_rdata_q
		: cfg_hit     ? {31'h0000_0000, configure_done_flag_q}
		: port_hit[0] ? 32'(downstream_status_control[0])
		: port_hit[1] ? 32'(downstream_status_control[1])
		: 32'h0000_0000;

	// Routing is registered so it never glitches while software rewrites ownership.
	// [R2] [R3] default routing
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_q       <= 32'h0000_0000;
			route_companion_q <= '1;
		end else begin
			reg_rdata_q       <= rdata_d;
			route_companion_q <= owner_d;
		end
	end

	// ==========================================================
	// Checks
	route_zero_a: assert property (@(posedge clk_sys) disable iff (rst || aux_por)
		!configure_done_flag_q ##1 !configure_done_flag_q |=> route_companion_q == '1) // [R2]
		else $error("ports not routed to companion");
	route_one_a: assert property (@(posedge clk_sys) disable iff (rst || aux_por)
		cf_rise ##1 (reg_wr == 1'b0)[*2] |=> route_companion_q == '0) // [R3]
		else $error("ports not routed to enhanced controller");
	route_owner_a: assert property (@(posedge clk_sys) disable iff (rst)
		route_companion_q == $past(owner_d)) // [R14]
		else $error("routing differs from ownership");
	port_decode_a: assert property (@(posedge clk_sys) disable iff (rst || aux_por)
		reg_rd && reg_addr == 8'h68 |=> reg_rdata_q == $past(32'(downstream_status_control[1]))) // [R8]
		else $error("second port read at wrong offset");
	reset_port_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		aux_por |=> downstream_status_control[0].companion_owner && !downstream_status_control[0].link_enabled && !downstream_status_control[0].connect_change) // [R4]
		else $error("aux reset did not clear port");
	reset_idle_a: assert property (@(posedge clk_sys) disable iff (1'b0)
		rst |=> !downstream_status_control[1].link_enabled && !downstream_status_control[1].connect_status && !configure_done_flag_q) // [R5]
		else $error("port not idle after reset");
	cover_cfg_c: cover property (@(posedge clk_sys) disable iff (rst) cf_rise);
	cover_read_c: cover property (@(posedge clk_sys) disable iff (rst) reg_rd && port_hit[0]);

endmodule : uhprs_top

// >>> uhprs_dev_model.sv
`timescale 1ns/1ps
module uhprs_dev_model
	import uhprs_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic [NPORT-1:0] attach_cmd,
	input  wire logic [NPORT-1:0] oc_cmd,
	output uhprs_pin_t [NPORT-1:0] port_pin
);
	// ==========================================================
	// Device pins
	// A detached port sits in SE0, as its pull-downs leave it.
	initial port_pin = '0;
	always @(posedge clk_sys) begin
		for (int i = 0; i < NPORT; i++) begin
			port_pin[i].attach      <= attach_cmd[i];
			port_pin[i].overcurrent <= oc_cmd[i];
			port_pin[i].line_state  <= attach_cmd[i] ? 2'h1 : 2'h0;
		end
	end
endmodule : uhprs_dev_model

// >>> usb_host_port_routing_status_tb_top.sv
`timescale 1ns/1ps
module usb_host_port_routing_status_tb_top
	import uhprs_pkg::*;
;
	// Power settle wait, shortened from the real settle time.
	localparam int SETTLE_CYC = 5;
	logic                   clk_sys = 1'b0;
	logic                   rst     = 1'b1;
	logic                   aux_por = 1'b0;
	logic                   reg_wr  = 1'b0;
	logic                   reg_rd  = 1'b0;
	logic [AW-1:0]          reg_addr  = '0;
	logic [31:0]            reg_wdata = '0;
	logic [NPORT-1:0]       attach_cmd = '0;
	logic [NPORT-1:0]       oc_cmd     = '0;
	uhprs_pin_t [NPORT-1:0] port_pin;
	logic [31:0]            reg_rdata_q;
	logic                   configure_done_flag_q;
	logic [NPORT-1:0]       route_companion_q;
	logic [NPORT-1:0]       wake_q;
	int                     n_fail  = 0;
	int                     checked = 0;

	always #20 clk_sys = ~clk_sys;

	uhprs_top u_uhprs_top (.clk_sys(clk_sys), .rst(rst), .aux_por(aux_por), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .port_pin(port_pin), .reg_rdata_q(reg_rdata_q),
		.configure_done_flag_q(configure_done_flag_q), .route_companion_q(route_companion_q), .wake_q(wake_q));
	uhprs_dev_model u_uhprs_dev_model (.clk_sys(clk_sys), .attach_cmd(attach_cmd), .oc_cmd(oc_cmd),
		.port_pin(port_pin));

	// ==========================================================
	// Bench tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk($sformatf("register %h", a), exp, reg_rdata_q);
	endtask : rd
	task automatic wake(input int n, input logic e);
		logic s;
		s = 1'b0;
		repeat (4) begin
			@(negedge clk_sys);
			s |= wake_q[n];
		end
		chk("wake pulse", {31'h0, e}, {31'h0, s});
	endtask : wake
	task automatic ev(input int k);
		@(posedge clk_sys);
		if (k == 0) attach_cmd[0] <= 1'b1;
		else if (k == 1) attach_cmd[0] <= 1'b0;
		else oc_cmd[0] <= 1'b1;
	endtask : ev
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Tests
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h60, 32'h0);
		rd(8'h64, PORT_RESET);
		chk("route", 32'h3, {30'h0, route_companion_q});
		$display("test reset values done");
		// Reserved bits always go out as zero.
		wr(8'h68, 32'h0070_0000);
		rd(8'h68, 32'h0070_2000);
		rd(8'h64, PORT_RESET);
		rd(8'h6c, 32'h0);
		wr(8'h64, 32'h0000_2035);
		rd(8'h64, PORT_RESET);
		$display("test decode and read-only done");
		// Configure flag goes last, once the ports are set up.
		wr(8'h60, 32'h1);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("flag", 32'h1, {31'h0, configure_done_flag_q});
		chk("route", 32'h0, {30'h0, route_companion_q});
		rd(8'h64, 32'h0);
		rd(8'h68, 32'h0070_0000);
		$display("test configure done");
		wr(8'h64, 32'h0000_1000);
		// Power must settle before any state change.
		repeat (SETTLE_CYC) @(posedge clk_sys);
		ev(0);
		wake(0, 1'b0);
		ev(1);
		wake(0, 1'b0);
		for (int k = 0; k < 3; k++) begin
			wr(8'h64, 32'h0000_1000 | (32'h1 << (20 + k)));
			ev(k);
			wake(0, 1'b1);
		end
		wake(1, 1'b0);
		$display("test wake events done");
		@(posedge clk_sys);
		oc_cmd <= '0;
		ev(0);
		repeat (2) @(posedge clk_sys);
		wr(8'h64, 32'h0000_1004);
		rd(8'h64, 32'h0000_1427);
		wr(8'h64, 32'h0000_1006);
		rd(8'h64, 32'h0000_1425);
		ev(1);
		repeat (2) @(posedge clk_sys);
		rd(8'h64, 32'h0000_102a);
		$display("test link enable done");
		@(posedge clk_sys);
		aux_por <= 1'b1;
		@(posedge clk_sys);
		aux_por <= 1'b0;
		rd(8'h60, 32'h1);
		rd(8'h68, PORT_RESET);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h60, 32'h0);
		rd(8'h64, PORT_RESET);
		chk("route", 32'h3, {30'h0, route_companion_q});
		$display("test resets done");
		report_and_stop();
	end

	initial begin
		#100us;
		n_fail++;
		report_and_stop();
	end
endmodule : usb_host_port_routing_status_tb_top
